// ==== core/ldr_cfg.svh ====
// offsets, reset values, masks and codes of the routing block
`ifndef LDR_CFG_SVH
`define LDR_CFG_SVH
// register indices; byte address is four times the index
`define LDR_IDX_LDN   8'h07
`define LDR_IDX_STS   8'h08
`define LDR_IDX_ACT   8'h30
`define LDR_IDX_IRQ   8'h70
`define LDR_IDX_DMA   8'h74
`define LDR_IDX_FMODE 8'hF0
`define LDR_IDX_FOPT  8'hF1
`define LDR_IDX_FTYPE 8'hF2
`define LDR_IDX_FRSV  8'hF3
`define LDR_IDX_FDRV0 8'hF4
`define LDR_IDX_FDRV1 8'hF5
// reset values
`define LDR_RST_LDN   8'h00
`define LDR_RST_ACT   8'h00
`define LDR_RST_IRQ   8'h00
`define LDR_RST_DMA   8'h04
`define LDR_RST_FMODE 8'h0E
`define LDR_RST_FOPT  8'h00
`define LDR_RST_FTYPE 8'hFF
`define LDR_RST_FDRV  8'h00
// writable bits; the rest read as zero
`define LDR_MSK_ACT   8'h01
`define LDR_MSK_IRQ   8'h0F
`define LDR_MSK_DMA   8'h07
`define LDR_MSK_FMODE 8'hDF
`define LDR_MSK_FOPT  8'hCC
`define LDR_MSK_FDRV  8'h5B
// field positions
`define LDR_DMA_NONE_BIT 2
// logical device numbers
`define LDR_LD_FDC  8'h00
`define LDR_LD_PP   8'h03
`define LDR_LD_UART 8'h04
// extended-capability mode codes with interrupt on while service interrupt is clear
`define LDR_ECR_FIFO 3'h2
`define LDR_ECR_ECP  3'h3
`define LDR_ECR_TEST 3'h6
`endif

// ==== core/ldr_pkg.sv ====
// types shared by the routing block and its bench
package ldr_pkg;
   typedef struct packed {
      logic floppy_dma_irq_enable; // digital output register D3
      logic powered_down;
      logic irq;
      logic drq;
   } ldr_fdc_sts_t;
   typedef struct packed {
      logic       ecp_active;
      logic [2:0] ecr_mode;
      logic       printer_irq_gate;
      logic       ecp_service_interrupt;
      logic       ecp_dma_gate;
      logic       irq;
      logic       printer_dma_request;
   } ldr_pp_sts_t;
   typedef struct packed {
      logic [3:0] uart_interrupt_enables;
      logic       uart_aux_output_two;
      logic       dma_enable;
      logic       irq;
      logic       drq;
   } ldr_uart_sts_t;
   typedef struct packed {
      logic [7:0] mode;
      logic [7:0] option;
      logic [7:0] drive_type;
      logic [7:0] drive0;
      logic [7:0] drive1;
   } ldr_fdc_cfg_t;
   typedef enum logic [1:0] {
      LDR_ST_IDLE = 2'b01,
      LDR_ST_DONE = 2'b10
   } ldr_apb_st_t;
endpackage

// ==== core/ldr_route.sv ====
// logical-device interrupt and dma routing with floppy config bytes
//
// Notes on behaviour
// - 0x70 low nibble picks interrupt line, 0 none
// - routed interrupts are active-high edge signals
// - floppy interrupt needs nonzero select and enable
// - printer interrupt needs gate, or an on code in extended mode; extended mode needs service clear
// - serial interrupt needs any enable and aux two
// - unselected interrupt lines stay high impedance
// - 0x74 low three bits pick channel 0-3
// - dma channel needs valid select and device enable
// - unselected dma request lines stay high impedance
// - block-level disables also gate routed outputs
// - floppy disabled or powered down floats outputs
// - serial aux two clear floats its interrupt
// - standard modes: printer gate clear floats interrupt
// - extended mode: dma by gate, interrupt per code
// - config bytes reset only by hard reset
// - floppy mode bits 0, 1 and 4
// - floppy mode bits 3:2 pick interface personality
// - floppy mode bits 6, 7 control output drive
// - option register density and boot drive fields
// - drive type storage; 0xF3 reads zero
// - per-drive type, rate table, precomp disable
`timescale 1ns/1ps
`include "ldr_cfg.svh"
module ldr_route #(
   parameter int ADDR_W = 10
) (
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [ADDR_W-1:0]     paddr,
   input  wire logic [31:0]           pwdata,
   output logic                       pready,
   output logic [31:0]                prdata,
   output logic                       pslverr,
   input  wire ldr_pkg::ldr_fdc_sts_t  fdc_sts,
   input  wire ldr_pkg::ldr_pp_sts_t   pp_sts,
   input  wire ldr_pkg::ldr_uart_sts_t uart_sts,
   input  wire logic [2:0]            base_valid,
   input  wire logic [3:0]            dma_ack_n,
   output logic [15:1]                irq_out,
   output logic [15:1]                irq_oe_n,
   output logic [3:0]                 dma_request_outputs,
   output logic [3:0]                 dma_req_oe_n,
   output logic [2:0]                 dev_dack,
   output ldr_pkg::ldr_fdc_cfg_t      fdc_cfg
);

   // bank 0 floppy, bank 1 printer, bank 2 serial
   localparam int NB = 3;

   // the register index sits in paddr bits 9:2, so a narrower bus cannot work
   if (ADDR_W < 10) begin : g_addr_chk
      $error("ADDR_W too small for register map");
   end

   ////////////////////////////////////////////////////////////////
   // register state

   logic [7:0]           ldn_q;
   logic [7:0]           act_q [NB];
   logic [7:0]           irq_q [NB];
   logic [7:0]           dma_q [NB];
   ldr_pkg::ldr_fdc_cfg_t cfg_q;
   ldr_pkg::ldr_apb_st_t  st_q;
   logic                 rdy_q;
   logic [31:0]          rdata_q;
   logic                 err_q;

   ////////////////////////////////////////////////////////////////
   // apb decode

   logic [7:0] idx;
   logic       aligned;
   logic       bank_vld;
   logic [1:0] bank;
   logic       is_fdc;
   logic       acc;
   logic       wr_en;

   assign idx      = paddr[9:2];
   assign aligned  = (paddr[1:0] == 2'h0);
   assign is_fdc   = (ldn_q == `LDR_LD_FDC);
   assign bank_vld = is_fdc | (ldn_q == `LDR_LD_PP) | (ldn_q == `LDR_LD_UART);
   assign bank     = (ldn_q == `LDR_LD_PP)   ? 2'h1 :
                     (ldn_q == `LDR_LD_UART) ? 2'h2 : 2'h0;
   // access phase seen while the answer is not yet out
   assign acc      = psel & penable & (st_q == ldr_pkg::LDR_ST_IDLE);
   // writes land only on the edge that samples pready high
   assign wr_en    = psel & penable & pwrite
                   & (st_q == ldr_pkg::LDR_ST_DONE) & ~err_q;

   logic hit_ldn, hit_sts, hit_act, hit_irq, hit_dma;
   logic hit_fm, hit_fo, hit_ft, hit_fr, hit_d0, hit_d1;
   logic mapped;

   assign hit_ldn = aligned & (idx == `LDR_IDX_LDN);
   assign hit_sts = aligned & (idx == `LDR_IDX_STS);
   assign hit_act = aligned & (idx == `LDR_IDX_ACT) & bank_vld;
   assign hit_irq = aligned & (idx == `LDR_IDX_IRQ) & bank_vld;
   assign hit_dma = aligned & (idx == `LDR_IDX_DMA) & bank_vld;
   // vendor bytes at 0xF0 and up belong to the floppy device only
   assign hit_fm  = aligned & is_fdc & (idx == `LDR_IDX_FMODE);
   assign hit_fo  = aligned & is_fdc & (idx == `LDR_IDX_FOPT);
   assign hit_ft  = aligned & is_fdc & (idx == `LDR_IDX_FTYPE);
   assign hit_fr  = aligned & is_fdc & (idx == `LDR_IDX_FRSV);
   assign hit_d0  = aligned & is_fdc & (idx == `LDR_IDX_FDRV0);
   assign hit_d1  = aligned & is_fdc & (idx == `LDR_IDX_FDRV1);
   assign mapped  = hit_ldn | hit_sts | hit_act | hit_irq | hit_dma
                  | hit_fm | hit_fo | hit_ft | hit_fr | hit_d0 | hit_d1;

   logic [7:0] wb;
   assign wb = pwdata[7:0];

   ////////////////////////////////////////////////////////////////
   // per-device gating

   logic [NB-1:0] act;
   logic [NB-1:0] irq_gate;
   logic [NB-1:0] dma_gate;
   logic [NB-1:0] dev_irq;
   logic [NB-1:0] dev_drq;
   logic          ecr_on;

   // floppy: enable bit and power state gate both paths
   assign irq_gate[0] = fdc_sts.floppy_dma_irq_enable & ~fdc_sts.powered_down;
   assign dma_gate[0] = fdc_sts.floppy_dma_irq_enable & ~fdc_sts.powered_down;
   assign dev_irq[0]  = fdc_sts.irq;
   assign dev_drq[0]  = fdc_sts.drq;

   // printer: fifo, ecp and test codes keep the interrupt on
   assign ecr_on = (pp_sts.ecr_mode == `LDR_ECR_FIFO)
                 | (pp_sts.ecr_mode == `LDR_ECR_ECP)
                 | (pp_sts.ecr_mode == `LDR_ECR_TEST);
   assign irq_gate[1] = pp_sts.ecp_active
                      ? ((ecr_on | pp_sts.printer_irq_gate)
                         & ~pp_sts.ecp_service_interrupt)
                      : pp_sts.printer_irq_gate;
   // outside extended mode the printer has no dma path
   assign dma_gate[1] = pp_sts.ecp_active & pp_sts.ecp_dma_gate;
   assign dev_irq[1]  = pp_sts.irq;
   assign dev_drq[1]  = pp_sts.printer_dma_request;

   // serial: any enable plus aux output two
   assign irq_gate[2] = (|uart_sts.uart_interrupt_enables)
                      & uart_sts.uart_aux_output_two;
   assign dma_gate[2] = uart_sts.dma_enable;
   assign dev_irq[2]  = uart_sts.irq;
   assign dev_drq[2]  = uart_sts.drq;

   ////////////////////////////////////////////////////////////////
   // routing permission per bank

   logic [NB-1:0] irq_ok;
   logic [NB-1:0] dma_ok;

   genvar b;
   generate
      for (b = 0; b < NB; b++) begin : g_bank
         // activate bit and decoded base address come first
         assign act[b]    = act_q[b][0] & base_valid[b];
         assign irq_ok[b] = act[b] & irq_gate[b]
                          & (irq_q[b][3:0] != 4'h0);
         assign dma_ok[b] = act[b] & dma_gate[b]
                          & ~dma_q[b][`LDR_DMA_NONE_BIT];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////
   // interrupt lines

   logic [15:1] line_drv;
   logic [15:1] line_lvl;

   genvar n;
   generate
      for (n = 1; n <= 15; n++) begin : g_line
         logic [NB-1:0] sel;
         for (b = 0; b < NB; b++) begin : g_sel
            assign sel[b] = irq_ok[b] & (irq_q[b][3:0] == 4'(n));
         end
         // shared lines are simply or-ed; no conflict check
         assign line_drv[n] = |sel;
         assign line_lvl[n] = |(sel & dev_irq);
      end
   endgenerate

   ////////////////////////////////////////////////////////////////
   // dma channels

   logic [3:0] ch_drv;
   logic [3:0] ch_lvl;
   logic [3:0] ack_s1_q;
   logic [3:0] ack_s2_q;
   logic [3:0] ack_s3_q;
   logic [3:0] ack_q;
   logic [3:0] ack_d;
   logic [2:0] dack_d;

   genvar c;
   generate
      for (c = 0; c < 4; c++) begin : g_ch
         logic [NB-1:0] sel;
         for (b = 0; b < NB; b++) begin : g_sel
            assign sel[b] = dma_ok[b] & (dma_q[b][1:0] == 2'(c));
         end
         assign ch_drv[c] = |sel;
         assign ch_lvl[c] = |(sel & dev_drq);
      end
      for (b = 0; b < NB; b++) begin : g_ack
         // acknowledge only reaches a device that owns the channel
         assign dack_d[b] = dma_ok[b] & ack_q[dma_q[b][1:0]];
      end
   endgenerate

   // filtered acknowledge changes once stages two and three agree
   assign ack_d = (ack_s2_q & ack_s3_q) | (ack_q & (ack_s2_q | ack_s3_q));

   // acknowledge pins come from the host, so they are synchronised
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ack_s1_q <= 4'h0;
         ack_s2_q <= 4'h0;
         ack_s3_q <= 4'h0;
         ack_q    <= 4'h0;
      end else begin
         ack_s1_q <= ~dma_ack_n;
         ack_s2_q <= ack_s1_q;
         ack_s3_q <= ack_s2_q;
         ack_q    <= ack_d;
      end
   end

   ////////////////////////////////////////////////////////////////
   // status byte and read mux

   logic [7:0] sts_b;
   logic [7:0] rd_b;

   // shows which banks currently route an interrupt or dma path
   assign sts_b = {1'h0, dma_ok, 1'h0, irq_ok};

   always_comb begin
      rd_b = 8'h00;
      case (1'b1)
         hit_ldn: rd_b = ldn_q;
         hit_sts: rd_b = sts_b;
         hit_act: rd_b = act_q[bank];
         hit_irq: rd_b = irq_q[bank];
         hit_dma: rd_b = dma_q[bank];
         hit_fm:  rd_b = cfg_q.mode;
         hit_fo:  rd_b = cfg_q.option;
         hit_ft:  rd_b = cfg_q.drive_type;
         hit_fr:  rd_b = 8'h00;
         hit_d0:  rd_b = cfg_q.drive0;
         hit_d1:  rd_b = cfg_q.drive1;
         default: rd_b = 8'h00;
      endcase
   end

   ////////////////////////////////////////////////////////////////
   // apb answer: one wait state, data and error from flops

   ldr_pkg::ldr_apb_st_t st_d;

   always_comb begin
      case (st_q)
         ldr_pkg::LDR_ST_IDLE: st_d = acc ? ldr_pkg::LDR_ST_DONE : ldr_pkg::LDR_ST_IDLE;
         ldr_pkg::LDR_ST_DONE: st_d = ldr_pkg::LDR_ST_IDLE;
         default:              st_d = ldr_pkg::LDR_ST_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_q    <= ldr_pkg::LDR_ST_IDLE;
         rdy_q   <= 1'h0;
         rdata_q <= 32'h0000_0000;
         err_q   <= 1'h0;
      end else begin
         st_q  <= st_d;
         rdy_q <= acc;
         // error stands only beside ready, never after the transfer
         err_q <= acc & ~mapped;
         if (acc) begin
            rdata_q <= {24'h00_0000, rd_b};
         end
      end
   end

   assign pready  = rdy_q;
   assign prdata  = rdata_q;
   assign pslverr = err_q;

   ////////////////////////////////////////////////////////////////
   // configuration writes; rst_n stands for the hard resets only

   // device number and per-bank routing selects
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ldn_q <= `LDR_RST_LDN;
         for (int i = 0; i < NB; i++) begin
            act_q[i] <= `LDR_RST_ACT;
            irq_q[i] <= `LDR_RST_IRQ;
            dma_q[i] <= `LDR_RST_DMA;
         end
      end else if (wr_en) begin
         if (hit_ldn) ldn_q <= wb;
         if (hit_act) act_q[bank] <= wb & `LDR_MSK_ACT;
         if (hit_irq) irq_q[bank] <= wb & `LDR_MSK_IRQ;
         if (hit_dma) dma_q[bank] <= wb & `LDR_MSK_DMA;
      end
   end

   // floppy configuration bytes; reserved bits forced to zero
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cfg_q.mode       <= `LDR_RST_FMODE;
         cfg_q.option     <= `LDR_RST_FOPT;
         cfg_q.drive_type <= `LDR_RST_FTYPE;
         cfg_q.drive0     <= `LDR_RST_FDRV;
         cfg_q.drive1     <= `LDR_RST_FDRV;
      end else if (wr_en) begin
         if (hit_fm) cfg_q.mode <= wb & `LDR_MSK_FMODE;
         if (hit_fo) cfg_q.option <= wb & `LDR_MSK_FOPT;
         if (hit_ft) cfg_q.drive_type <= wb;
         if (hit_d0) cfg_q.drive0 <= wb & `LDR_MSK_FDRV;
         if (hit_d1) cfg_q.drive1 <= wb & `LDR_MSK_FDRV;
      end
   end

   // floppy core decodes mode, option and drive fields itself
   assign fdc_cfg = cfg_q;

   ////////////////////////////////////////////////////////////////
   // pin outputs, registered; enable low means driven

   logic [15:1] irq_q_o;
   logic [15:1] irq_oe_q;
   logic [3:0]  drq_q_o;
   logic [3:0]  drq_oe_q;
   logic [2:0]  dack_q;

   // one cycle of latency traded for glitch-free pins
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         irq_q_o  <= 15'h0000;
         irq_oe_q <= 15'h7FFF;
         drq_q_o  <= 4'h0;
         drq_oe_q <= 4'hF;
         dack_q   <= 3'h0;
      end else begin
         irq_q_o  <= line_lvl;
         irq_oe_q <= ~line_drv;
         drq_q_o  <= ch_lvl;
         drq_oe_q <= ~ch_drv;
         dack_q   <= dack_d;
      end
   end

   assign irq_out             = irq_q_o;
   assign irq_oe_n            = irq_oe_q;
   assign dma_request_outputs = drq_q_o;
   assign dma_req_oe_n        = drq_oe_q;
   assign dev_dack            = dack_q;

endmodule

// ==== bench/ldr_route_checker.sv ====
// port assertions for the interrupt and dma routing block
`timescale 1ns/1ps
module ldr_route_checker (
   input wire logic                   clk,
   input wire logic                   rst_n,
   input wire logic                   psel,
   input wire logic                   penable,
   input wire logic                   pwrite,
   input wire logic                   pready,
   input wire logic                   pslverr,
   input wire logic [31:0]            prdata,
   input wire ldr_pkg::ldr_fdc_sts_t  fdc_sts,
   input wire ldr_pkg::ldr_pp_sts_t   pp_sts,
   input wire ldr_pkg::ldr_uart_sts_t uart_sts,
   input wire logic [2:0]             base_valid,
   input wire logic [3:0]             dma_ack_n,
   input wire logic [15:1]            irq_oe_n,
   input wire logic [3:0]             dma_req_oe_n,
   input wire logic [2:0]             dev_dack,
   input wire ldr_pkg::ldr_fdc_cfg_t  fdc_cfg
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////////////////////////////////////////////
   // reset check must not be disabled by the reset it watches
   a_reset_float: assert property (disable iff (1'h0)
      !rst_n |=> &irq_oe_n && &dma_req_oe_n && dev_dack == 3'h0
      && fdc_cfg == {8'h0E, 8'h00, 8'hFF, 8'h00, 8'h00}) else $error("outputs not at reset");
   a_ready_wait: assert property (psel && $rose(penable) |=> pready)
      else $error("no answer one cycle after access");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready held too long");
   a_err_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
      else $error("refused read returned data");
   a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
      else $error("upper read lanes not zero");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   // two cycles of cause leave one cycle of margin over the single output flop
   a_base_float: assert property ((base_valid == 3'h0) [*2] |=> &irq_oe_n && &dma_req_oe_n)
      else $error("line driven without valid base");
   a_fdc_dack: assert property (
      (!fdc_sts.floppy_dma_irq_enable || fdc_sts.powered_down) [*2] |=> !dev_dack[0])
      else $error("floppy acknowledged while disabled");
   a_pp_dack: assert property ((!pp_sts.ecp_active || !pp_sts.ecp_dma_gate) [*2]
      |=> !dev_dack[1]) else $error("printer acknowledged while gated");
   a_uart_dack: assert property (!uart_sts.dma_enable [*2] |=> !dev_dack[2])
      else $error("serial acknowledged while gated");
   a_ack_quiet: assert property ((&dma_ack_n) [*8] |=> dev_dack == 3'h0)
      else $error("acknowledge without host pin");
   a_cfg_write: assert property ($changed(fdc_cfg) |-> $past(pready && pwrite))
      else $error("config byte changed without write");
endmodule

// ==== bench/ldr_host_model.sv ====
// host dma controller: acknowledges a driven request after a short or long delay
`timescale 1ns/1ps
module ldr_host_model (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       slow,
   input  wire logic [3:0] drq,
   input  wire logic [3:0] drq_oe_n,
   output logic      [3:0] dma_ack_n
);
   logic [3:0] cnt_q [4];
   initial dma_ack_n = 4'hF;
   // a floated request is never answered, so a released pin cannot hold an ack
   always @(posedge clk) begin
      for (int c = 0; c < 4; c++) begin
         if (!rst_n || drq_oe_n[c] !== 1'h0 || drq[c] !== 1'h1) begin
            cnt_q[c] <= 4'h0;
            dma_ack_n[c] <= 1'h1;
         end else begin
            if (cnt_q[c] != 4'hF) cnt_q[c] <= cnt_q[c] + 4'h1;
            dma_ack_n[c] <= !(cnt_q[c] >= (slow ? 4'h6 : 4'h1));
         end
      end
   end
endmodule

// ==== bench/tb_logical_device_irq_dma_routing.sv ====
// self-checking bench for the interrupt and dma routing block
`timescale 1ns/1ps
module tb_logical_device_irq_dma_routing;
   logic        clk, rst_n, psel, penable, pwrite, slow, pready, pslverr, err;
   logic [9:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [2:0]  base_valid, dev_dack;
   logic [3:0]  dma_ack_n, dma_request_outputs, dma_req_oe_n;
   logic [15:1] irq_out, irq_oe_n;
   ldr_pkg::ldr_fdc_sts_t  fdc_sts;
   ldr_pkg::ldr_pp_sts_t   pp_sts;
   ldr_pkg::ldr_uart_sts_t uart_sts;
   ldr_pkg::ldr_fdc_cfg_t  fdc_cfg;
   int miscompares = 0;
   int n_checks = 0;
   int cycles = 0;
   // row: ldn[31:28] flags[27:24] (8 write, 1 refused) index[23:16] wdata[15:8] rdata[7:0]
   logic [31:0] rows [19] = '{32'h00700000, 32'h00740004, 32'h00F0000E, 32'h00F10000,
      32'h00F200FF, 32'h00F40000, 32'h00F50000, 32'h0870FF0F, 32'h0874FF07, 32'h08F0FFDF,
      32'h08F1FFCC, 32'h08F2A5A5, 32'h08F3FF00, 32'h08F4FF5B, 32'h08F5FF5B, 32'h0950FF00,
      32'h39F0FF00, 32'h30740004, 32'h40700000};
   ////////////////////////////////////////////////////////////////////////////////
   always #10 clk = ~clk;
   // watchdog: the whole run needs under a thousand cycles
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         miscompares++;
         end_of_test();
      end
   end
   ldr_route #(.ADDR_W(10)) dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .fdc_sts(fdc_sts), .pp_sts(pp_sts), .uart_sts(uart_sts),
      .base_valid(base_valid), .dma_ack_n(dma_ack_n), .irq_out(irq_out),
      .irq_oe_n(irq_oe_n), .dma_request_outputs(dma_request_outputs),
      .dma_req_oe_n(dma_req_oe_n), .dev_dack(dev_dack), .fdc_cfg(fdc_cfg));
   ldr_host_model host (.clk(clk), .rst_n(rst_n), .slow(slow), .drq(dma_request_outputs),
      .drq_oe_n(dma_req_oe_n), .dma_ack_n(dma_ack_n));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic end_of_test();
      if (miscompares == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one apb transfer; held until ready is seen high at a rising edge
   task automatic apb(input logic [7:0] idx, input logic wr, input logic [7:0] wd);
      int t;
      t = 0;
      @(posedge clk);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= {idx, 2'h0};
      pwdata <= {24'h0, wd};
      @(posedge clk);
      penable <= 1'h1;
      do @(posedge clk); while (pready !== 1'h1 && ++t < 50);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      if (t >= 50) miscompares++;
   endtask
   // routing is one flop behind its inputs; four edges leave margin
   task automatic settle();
      repeat (4) @(posedge clk);
      #1;
   endtask
   task automatic wait_dack(input logic [2:0] exp);
      int t;
      t = 0;
      while (dev_dack !== exp && t < 40) begin
         @(posedge clk);
         t++;
      end
      #1;
      chk(dev_dack, exp);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'h0;
      rst_n = 1'h0;
      {psel, penable, pwrite, slow, paddr, pwdata} = '0;
      {fdc_sts, pp_sts, uart_sts} = '0;
      base_valid = 3'h7;
      repeat (4) @(posedge clk);
      rst_n <= 1'h1;
      #1;
      chk({irq_oe_n, dma_req_oe_n, dev_dack}, {15'h7FFF, 4'hF, 3'h0});
      chk(fdc_cfg, {8'h0E, 8'h00, 8'hFF, 8'h00, 8'h00});
      foreach (rows[i]) begin
         apb(8'h07, 1'h1, {4'h0, rows[i][31:28]});
         if (rows[i][27]) apb(rows[i][23:16], 1'h1, rows[i][15:8]);
         apb(rows[i][23:16], 1'h0, 8'h00);
         chk({err, rd}, {rows[i][24], 24'h0, rows[i][7:0]});
      end
      chk(fdc_cfg, {8'hDF, 8'hCC, 8'hA5, 8'h5B, 8'h5B});
      // floppy bank: every line and channel code
      apb(8'h07, 1'h1, 8'h00);
      apb(8'h30, 1'h1, 8'h01);
      fdc_sts <= 4'hA;
      for (int n = 0; n < 16; n++) begin
         apb(8'h70, 1'h1, n[7:0]);
         settle();
         chk(irq_oe_n, n == 0 ? 15'h7FFF : 15'h7FFF ^ (15'h1 << (n - 1)));
         if (n != 0) chk(irq_out[n], 1'h1);
      end
      for (int c = 0; c < 8; c++) begin
         apb(8'h74, 1'h1, c[7:0]);
         settle();
         chk(dma_req_oe_n, c < 4 ? 4'hF ^ (4'h1 << c) : 4'hF);
      end
      apb(8'h70, 1'h1, 8'h06);
      apb(8'h74, 1'h1, 8'h02);
      fdc_sts <= 4'hB;
      wait_dack(3'h1);
      chk(dma_request_outputs[2], 1'h1);
      @(posedge clk);
      fdc_sts <= 4'h3;
      wait_dack(3'h0);
      chk({irq_oe_n[6], dma_req_oe_n[2]}, 2'h3);
      @(posedge clk);
      fdc_sts <= 4'hB;
      wait_dack(3'h1);
      @(posedge clk);
      fdc_sts <= 4'hF;
      wait_dack(3'h0);
      chk({irq_oe_n[6], dma_req_oe_n[2]}, 2'h3);
      @(posedge clk);
      fdc_sts <= 4'hA;
      base_valid <= 3'h0;
      settle();
      chk({irq_oe_n[6], dma_req_oe_n[2]}, 2'h3);
      @(posedge clk);
      base_valid <= 3'h7;
      // serial bank on line 3, apart from the floppy's line 6
      apb(8'h07, 1'h1, 8'h04);
      apb(8'h30, 1'h1, 8'h01);
      apb(8'h70, 1'h1, 8'h03);
      apb(8'h74, 1'h1, 8'h01);
      uart_sts <= 8'h0A;
      settle();
      chk(irq_oe_n[3], 1'h1);
      @(posedge clk);
      uart_sts <= 8'h4A;
      settle();
      chk({irq_oe_n[3], irq_out[3]}, 2'h1);
      @(posedge clk);
      uart_sts <= 8'h42;
      settle();
      chk(irq_oe_n[3], 1'h1);
      @(posedge clk);
      slow <= 1'h1;
      uart_sts <= 8'h4F;
      wait_dack(3'h4);
      @(posedge clk);
      uart_sts <= 8'h4B;
      wait_dack(3'h0);
      chk(dma_req_oe_n[1], 1'h1);
      // printer bank on line 7, channel 0
      apb(8'h07, 1'h1, 8'h03);
      apb(8'h30, 1'h1, 8'h01);
      apb(8'h70, 1'h1, 8'h07);
      apb(8'h74, 1'h1, 8'h00);
      pp_sts <= 9'h002;
      settle();
      chk(irq_oe_n[7], 1'h1);
      @(posedge clk);
      pp_sts <= 9'h012;
      settle();
      chk(irq_oe_n[7], 1'h0);
      for (int m = 0; m < 8; m++) begin
         @(posedge clk);
         pp_sts <= {1'h1, m[2:0], 5'h02};
         settle();
         chk(irq_oe_n[7], !(m == 2 || m == 3 || m == 6));
      end
      @(posedge clk);
      pp_sts <= {1'h1, 3'h3, 5'h0A};
      settle();
      chk(irq_oe_n[7], 1'h1);
      @(posedge clk);
      pp_sts <= {1'h1, 3'h3, 5'h07};
      wait_dack(3'h2);
      @(posedge clk);
      pp_sts <= {1'h0, 3'h3, 5'h17};
      wait_dack(3'h0);
      chk(dma_req_oe_n[0], 1'h1);
      // hard reset in mid-run: config back to defaults, driven lines float
      @(posedge clk);
      rst_n <= 1'h0;
      repeat (3) @(posedge clk);
      rst_n <= 1'h1;
      #1;
      chk({irq_oe_n, dma_req_oe_n, dev_dack}, {15'h7FFF, 4'hF, 3'h0});
      chk(fdc_cfg, {8'h0E, 8'h00, 8'hFF, 8'h00, 8'h00});
      end_of_test();
   end
endmodule
bind ldr_route ldr_route_checker u_chk (.clk(clk), .rst_n(rst_n), .psel(psel),
   .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .prdata(prdata),
   .fdc_sts(fdc_sts), .pp_sts(pp_sts), .uart_sts(uart_sts), .base_valid(base_valid),
   .dma_ack_n(dma_ack_n), .irq_oe_n(irq_oe_n), .dma_req_oe_n(dma_req_oe_n),
   .dev_dack(dev_dack), .fdc_cfg(fdc_cfg));
